// [rtl/dasp_top.sv]
// Purpose: Two full-duplex asynchronous serial ports with buffered receive
// Assumes: Pins synchronous to clk_i; timer 1 overflow given as a pulse
// Notes: Mode 0 shifts with shift_clk_o; other modes use 16x oversampling
`timescale 1ns/1ps
`default_nettype none
module dasp_top
  import dasp_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic timer1_ovf_i,
  input wire logic [1:0] rxd_i,
  output logic [1:0] txd_o,
  output logic [1:0] shift_clk_o,
  output logic [1:0] rxd_out_o,
  output logic [1:0] rxd_oe_o,
  output logic irq_o
);
  logic [7:0] rd_mux [2];
  logic [1:0] port_irq;
  logic [1:0] port_hit;
  logic [7:0] next_rdata;

  // Address decode: upper nibble picks the port
  assign port_hit[0] = (addr_i[7:4] == 4'h0);
  assign port_hit[1] = (addr_i[7:4] == DASP_PORT_STRIDE[7:4]);
  assign next_rdata = port_hit[0] ? rd_mux[0] : (port_hit[1] ? rd_mux[1] : 8'h00);

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= 8'h00;
      irq_o <= 1'b0;
    end else begin
      rdata_o <= rd_i ? next_rdata : 8'h00;
      irq_o <= |port_irq;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      logic [7:0] ctrl;
      logic [7:0] reload;
      logic [7:0] presc;
      logic [3:0] status;
      logic [2:0] sticky;
      logic [3:0] irq_en;
      logic [7:0] brg_cnt;
      logic [7:0] pre_cnt;
      logic [7:0] fix_cnt;
      logic tick;
      logic brg_tick;
      logic [1:0] mode;
      logic nine;
      logic shift_mode;
      logic wr_hit;
      logic rd_hit;
      logic [3:0] reg_sel;
      dasp_tx_state_t tx_st;
      dasp_rx_state_t rx_st;
      logic [8:0] tx_sh;
      logic [3:0] tx_os;
      logic [3:0] tx_bit;
      logic [8:0] rx_sh;
      logic [3:0] rx_os;
      logic [3:0] rx_bit;
      logic [7:0] rx_buf;
      logic rx_b8;
      logic shclk;
      logic ev_tx;
      logic ev_rx;
      logic ev_ovr;
      logic rx_accept;
      logic tx_load;
      logic rx_read;
      logic [3:0] clr_bits;
      logic [3:0] nbits;
      logic [7:0] fix_top;

      assign reg_sel = addr_i[3:0];
      assign wr_hit = wr_i && port_hit[p];
      assign rd_hit = rd_i && port_hit[p];
      assign mode = ctrl[DASP_CTRL_MODE_LO +: 2];
      assign nine = mode[1];
      assign shift_mode = (mode == DASP_MODE_SHIFT);
      assign nbits = nine ? 4'd9 : 4'd8;
      assign tx_load = wr_hit && (reg_sel == DASP_REG_DATA) && (tx_st == DASP_TX_IDLE);
      assign rx_read = rd_hit && (reg_sel == DASP_REG_DATA);
      assign clr_bits = (wr_hit && (reg_sel == DASP_REG_IRQ_CLR)) ? wdata_i[3:0] : 4'h0;
      // Fixed mode 2 tick period; second port has no fast option
      assign fix_top = (p == 0 && ctrl[DASP_CTRL_FAST]) ?
                       8'(DASP_MODE2_FAST_TICK - 1) : 8'(DASP_MODE2_SLOW_TICK - 1);
      assign brg_tick = (pre_cnt == 8'h00) && (brg_cnt == 8'h00);
      // Oversample tick source per mode
      assign tick = (mode == DASP_MODE_9FIX) ? (fix_cnt == 8'h00) :
                    ((p == 0 && ctrl[DASP_CTRL_T1SEL]) ? timer1_ovf_i : brg_tick);

      // Register reads; status shows own state
      assign rd_mux[p] = (reg_sel == DASP_REG_CTRL) ? ctrl :
                         (reg_sel == DASP_REG_DATA) ? rx_buf :
                         (reg_sel == DASP_REG_RELOAD) ? reload :
                         (reg_sel == DASP_REG_PRESC) ? presc :
                         (reg_sel == DASP_REG_STATUS) ? {4'h0, status} :
                         (reg_sel == DASP_REG_IRQ_EN) ? {4'h0, irq_en} :
                         (reg_sel == DASP_REG_NINTH) ? {7'h00, rx_b8} : 8'h00;
      assign port_irq[p] = |(status[2:0] & irq_en[2:0]);

      // Software registers
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          ctrl <= DASP_CTRL_RST;
          reload <= DASP_RELOAD_RST;
          presc <= DASP_PRESC_RST;
          irq_en <= 4'h0;
        end else if (wr_hit) begin
          if (reg_sel == DASP_REG_CTRL) ctrl <= wdata_i;
          if (reg_sel == DASP_REG_RELOAD) reload <= wdata_i;
          if (reg_sel == DASP_REG_PRESC) presc <= wdata_i;
          if (reg_sel == DASP_REG_IRQ_EN) irq_en <= wdata_i[3:0];
        end
      end

      // Reload generator behind a prescaler; underflow reloads both stages
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          pre_cnt <= 8'h00;
          brg_cnt <= 8'h00;
          fix_cnt <= 8'h00;
        end else begin
          pre_cnt <= (pre_cnt == 8'h00) ? presc : pre_cnt - 8'h01;
          if (pre_cnt == 8'h00) brg_cnt <= (brg_cnt == 8'h00) ? reload : brg_cnt - 8'h01;
          fix_cnt <= (fix_cnt == 8'h00) ? fix_top : fix_cnt - 8'h01;
        end
      end

      // Sticky flags; a new event wins over a same-cycle clear
      // Busy bit is live state, so it sits beside the sticky flops, not in them
      assign status = {(tx_st != DASP_TX_IDLE), sticky};
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          sticky <= 3'h0;
        end else begin
          sticky[DASP_ST_TXDONE] <= ev_tx | (sticky[DASP_ST_TXDONE] & ~clr_bits[0]);
          sticky[DASP_ST_RXDONE] <= ev_rx | (sticky[DASP_ST_RXDONE] & ~clr_bits[1] & ~rx_read);
          sticky[DASP_ST_OVERRUN] <= ev_ovr | (sticky[DASP_ST_OVERRUN] & ~clr_bits[2]);
        end
      end

      // Transmitter: start, data lowest first, optional ninth, stop
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          tx_st <= DASP_TX_IDLE;
          tx_sh <= 9'h1ff;
          tx_os <= 4'h0;
          tx_bit <= 4'h0;
          txd_o[p] <= 1'b1;
          shclk <= 1'b1;
          ev_tx <= 1'b0;
        end else begin
          ev_tx <= 1'b0;
          case (tx_st)
            DASP_TX_IDLE: begin
              txd_o[p] <= 1'b1;
              shclk <= 1'b1;
              if (tx_load) begin
                tx_sh <= {ctrl[DASP_CTRL_TB8], wdata_i};
                tx_os <= 4'h0;
                tx_bit <= 4'h0;
                tx_st <= shift_mode ? DASP_TX_DATA : DASP_TX_START;
              end
            end
            DASP_TX_START: begin
              txd_o[p] <= 1'b0;
              if (tick) begin
                tx_os <= tx_os + 4'h1;
                if (tx_os == 4'(DASP_OVERSAMPLE - 1)) tx_st <= DASP_TX_DATA;
              end
            end
            DASP_TX_DATA: begin
              // Mode 0 data leaves on the rx pin; txd stays idle for the line
              txd_o[p] <= shift_mode ? 1'b1 : tx_sh[0];
              if (shift_mode) begin
                // Clock over two: low half then high half per bit
                shclk <= ~shclk;
                if (!shclk) begin
                  tx_sh <= {1'b1, tx_sh[8:1]};
                  tx_bit <= tx_bit + 4'h1;
                  if (tx_bit == 4'd7) tx_st <= DASP_TX_STOP;
                end
              end else if (tick) begin
                tx_os <= tx_os + 4'h1;
                if (tx_os == 4'(DASP_OVERSAMPLE - 1)) begin
                  tx_sh <= {1'b1, tx_sh[8:1]};
                  tx_bit <= tx_bit + 4'h1;
                  if (tx_bit == nbits - 4'h1) tx_st <= DASP_TX_STOP;
                end
              end
            end
            DASP_TX_STOP: begin
              txd_o[p] <= 1'b1;
              shclk <= 1'b1;
              if (shift_mode || (tick && tx_os == 4'(DASP_OVERSAMPLE - 1))) begin
                tx_st <= DASP_TX_IDLE;
                ev_tx <= 1'b1;
              end else if (tick) begin
                tx_os <= tx_os + 4'h1;
              end
            end
            default: tx_st <= DASP_TX_IDLE;
          endcase
        end
      end

      // Mode 0 drives the data pin from the transmit shifter
      // Data moves only while the shift clock is low, so it stands at each rise
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          shift_clk_o[p] <= 1'b1;
          rxd_out_o[p] <= 1'b1;
          rxd_oe_o[p] <= 1'b0;
        end else begin
          shift_clk_o[p] <= shclk;
          if (!shclk) rxd_out_o[p] <= tx_sh[0];
          // Held through stop so the last bit outlives its clock rise
          rxd_oe_o[p] <= shift_mode && (tx_st == DASP_TX_DATA || tx_st == DASP_TX_STOP);
        end
      end

      // Frame acceptance: address filter in nine-bit modes
      assign rx_accept = !nine || !ctrl[DASP_CTRL_MPCE] || rx_sh[8];

      // Receiver: mid-bit sampling into its own shifter, then the buffer
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          rx_st <= DASP_RX_IDLE;
          rx_sh <= 9'h000;
          rx_os <= 4'h0;
          rx_bit <= 4'h0;
          rx_buf <= 8'h00;
          rx_b8 <= 1'b0;
          ev_rx <= 1'b0;
          ev_ovr <= 1'b0;
        end else begin
          ev_rx <= 1'b0;
          ev_ovr <= 1'b0;
          case (rx_st)
            DASP_RX_IDLE: begin
              rx_os <= 4'h0;
              rx_bit <= 4'h0;
              if (ctrl[DASP_CTRL_REN] && !shift_mode && tick && !rxd_i[p]) begin
                rx_st <= DASP_RX_START;
              end
            end
            DASP_RX_START: if (tick) begin
              rx_os <= rx_os + 4'h1;
              // False start if line returns high at mid-bit
              if (rx_os == 4'(DASP_OVERSAMPLE / 2 - 2) && rxd_i[p]) rx_st <= DASP_RX_IDLE;
              if (rx_os == 4'(DASP_OVERSAMPLE - 2)) begin
                rx_os <= 4'h0;
                rx_st <= DASP_RX_DATA;
              end
            end
            DASP_RX_DATA: if (tick) begin
              rx_os <= rx_os + 4'h1;
              if (rx_os == 4'(DASP_OVERSAMPLE / 2)) begin
                rx_sh <= nine ? {rxd_i[p], rx_sh[8:1]} : {1'b0, rxd_i[p], rx_sh[7:1]};
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == nbits - 4'h1) rx_st <= DASP_RX_STOP;
              end
            end
            DASP_RX_STOP: if (tick) begin
              rx_os <= rx_os + 4'h1;
              if (rx_os == 4'(DASP_OVERSAMPLE / 2)) begin
                rx_st <= DASP_RX_IDLE;
                if (rx_accept) begin
                  if (status[DASP_ST_RXDONE] && !rx_read) begin
                    ev_ovr <= 1'b1; // Newer byte dropped, older kept
                  end else begin
                    rx_buf <= rx_sh[7:0];
                    rx_b8 <= nine ? rx_sh[8] : rxd_i[p];
                    ev_rx <= 1'b1;
                  end
                end
              end
            end
            default: rx_st <= DASP_RX_IDLE;
          endcase
        end
      end
    end
  endgenerate
endmodule : dasp_top
`default_nettype wire

// [rtl/dasp_pkg.sv]
// Purpose: Constants for the dual asynchronous serial port block
// Assumes: Single peripheral clock at 250 MHz
// Notes: Register map is a plain strobe port, byte-wide data
package dasp_pkg;
  // Register offsets, port 0 at base, port 1 at base plus stride
  localparam logic [7:0] DASP_PORT_STRIDE = 8'h10;
  localparam logic [3:0] DASP_REG_CTRL = 4'h0;
  localparam logic [3:0] DASP_REG_DATA = 4'h1;
  localparam logic [3:0] DASP_REG_RELOAD = 4'h2;
  localparam logic [3:0] DASP_REG_PRESC = 4'h3;
  localparam logic [3:0] DASP_REG_STATUS = 4'h4;
  localparam logic [3:0] DASP_REG_IRQ_EN = 4'h5;
  localparam logic [3:0] DASP_REG_IRQ_CLR = 4'h6;
  localparam logic [3:0] DASP_REG_NINTH = 4'h7;
  // Control field positions
  localparam int DASP_CTRL_MODE_LO = 0;
  localparam int DASP_CTRL_REN = 2;
  localparam int DASP_CTRL_MPCE = 3;
  localparam int DASP_CTRL_FAST = 4;
  localparam int DASP_CTRL_T1SEL = 5;
  localparam int DASP_CTRL_TB8 = 6;
  // Status bit positions
  localparam int DASP_ST_TXDONE = 0;
  localparam int DASP_ST_RXDONE = 1;
  localparam int DASP_ST_OVERRUN = 2;
  localparam int DASP_ST_TXBUSY = 3;
  // Reset values
  localparam logic [7:0] DASP_CTRL_RST = 8'h00;
  localparam logic [7:0] DASP_RELOAD_RST = 8'h00;
  localparam logic [7:0] DASP_PRESC_RST = 8'h00;
  // Fixed rate dividers: mode 0 clocks per bit, oversample ticks per bit, mode 2 tick periods, counter width
  localparam int DASP_MODE0_DIV = 2;
  localparam int DASP_OVERSAMPLE = 16;
  localparam int DASP_MODE2_FAST_TICK = 2;
  localparam int DASP_MODE2_SLOW_TICK = 4;
  localparam int DASP_CNT_W = 8;
  // Operating modes
  localparam logic [1:0] DASP_MODE_SHIFT = 2'h0;
  localparam logic [1:0] DASP_MODE_8VAR = 2'h1;
  localparam logic [1:0] DASP_MODE_9FIX = 2'h2;
  localparam logic [1:0] DASP_MODE_9VAR = 2'h3;
  typedef enum logic [3:0] {
    DASP_TX_IDLE = 4'h1,
    DASP_TX_START = 4'h2,
    DASP_TX_DATA = 4'h4,
    DASP_TX_STOP = 4'h8
  } dasp_tx_state_t;
  typedef enum logic [3:0] {
    DASP_RX_IDLE = 4'h1,
    DASP_RX_START = 4'h2,
    DASP_RX_DATA = 4'h4,
    DASP_RX_STOP = 4'h8
  } dasp_rx_state_t;
endpackage : dasp_pkg

// [dv/dasp_top_assertions.sv]
// Purpose: Pin-level checks on the serial port block
// Assumes: One clock, reset_i async active high
// Notes: Bound to dasp_top below
`timescale 1ns/1ps
`default_nettype none
module dasp_top_chk (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic [1:0] txd_o,
  input wire logic [1:0] shift_clk_o,
  input wire logic [1:0] rxd_oe_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  // Shortest bit is 16 clocks, so every low bit outlasts 8
  sequence s_low0;
    !txd_o[0] [*8];
  endsequence
  sequence s_low1;
    !txd_o[1] [*8];
  endsequence
  // Pins idle on the first edge out of reset
  a_reset_idle: assert property ($fell(reset_i) |-> txd_o == 2'b11 && rxd_oe_o == 2'b00 && !irq_o)
    else $error("Pins not idle after reset");
  // Read data only in the cycle after a read strobe
  a_read_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("Read data outside its cycle");
  a_unmapped_zero: assert property (rd_i && addr_i[7:5] != 3'b000 |=> rdata_o == 8'h00)
    else $error("Unmapped read not zero");
  a_start_width0: assert property ($fell(txd_o[0]) |-> s_low0)
    else $error("Port 0 low bit too short");
  a_start_width1: assert property ($fell(txd_o[1]) |-> s_low1)
    else $error("Port 1 low bit too short");
  // Shift clock at clock over two: low for exactly one cycle
  a_shift_rate0: assert property ($fell(shift_clk_o[0]) |=> shift_clk_o[0])
    else $error("Port 0 shift clock rate");
  a_shift_rate1: assert property ($fell(shift_clk_o[1]) |=> shift_clk_o[1])
    else $error("Port 1 shift clock rate");
  // Sticky flags: the request only drops after software touched a register
  a_irq_hold: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3)
    || $past(rd_i, 2) || $past(rd_i, 3))
    else $error("Interrupt dropped on its own");
endmodule : dasp_top_chk
bind dasp_top dasp_top_chk u_dasp_top_chk (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .txd_o(txd_o), .shift_clk_o(shift_clk_o),
  .rxd_oe_o(rxd_oe_o), .irq_o(irq_o));
`default_nettype wire

// [dv/dasp_line_model.sv]
// Purpose: Remote serial transceiver on one port's line
// Assumes: Bench sets bit_clks and n_bits per test
// Notes: Frame start 0, data LSB first, stop 1
`timescale 1ns/1ps
`default_nettype none
module dasp_line_model (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o,
  output logic got_o,
  output logic [8:0] frame_o
);
  int bit_clks = 16;
  int n_bits = 8;
  logic [8:0] w;
  initial begin
    rxd_o = 1'b1;
    got_o = 1'b0;
    frame_o = 9'h000;
  end
  // Drive one frame, lowest bit first
  task automatic send(input logic [8:0] v);
    rxd_o <= 1'b0;
    repeat (bit_clks) @(posedge clk_i);
    for (int i = 0; i < n_bits; i++) begin
      rxd_o <= v[i];
      repeat (bit_clks) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    repeat (bit_clks) @(posedge clk_i);
  endtask : send
  // Mid-bit sampling; a frame without a high stop bit is not reported
  always begin
    @(negedge txd_i);
    w = 9'h000;
    repeat (bit_clks / 2) @(posedge clk_i);
    for (int i = 0; i < n_bits; i++) begin
      repeat (bit_clks) @(posedge clk_i);
      w[i] = txd_i;
    end
    repeat (bit_clks) @(posedge clk_i);
    if (txd_i) begin
      frame_o <= w;
      got_o <= 1'b1;
      @(posedge clk_i);
      got_o <= 1'b0;
    end
  end
endmodule : dasp_line_model
`default_nettype wire

// [dv/dual_async_serial_port_bench.sv]
// Purpose: Self-checking bench for dasp_top
// Assumes: One line model per port
// Notes: Reads and frames are checked from notes
`timescale 1ns/1ps
`default_nettype none
module dual_async_serial_port_bench;
  import dasp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic t1_i = 1'b0;
  logic rd_d = 1'b0;
  logic [1:0] sck_d = 2'b11;
  logic [7:0] sh = 8'h00;
  logic [7:0] exp_q[$];
  logic [8:0] txq0[$], txq1[$];
  int n_mismatch = 0, checked = 0, cycles = 0, t1_per = 0, n_sck = 0;
  wire logic [7:0] rdata_o;
  wire logic [8:0] fr0, fr1;
  wire logic [1:0] txd_o, sck_o, rxd_out_o, rxd_oe_o, mdl_rxd, got, rxd_line;
  wire logic irq_o;
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // The device owns the rx pin while it drives it, else the far end does
  assign rxd_line = (rxd_oe_o & rxd_out_o) | (~rxd_oe_o & mdl_rxd);
  dasp_top u_dasp_top (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer1_ovf_i(t1_i), .rxd_i(rxd_line),
    .txd_o(txd_o), .shift_clk_o(sck_o), .rxd_out_o(rxd_out_o), .rxd_oe_o(rxd_oe_o),
    .irq_o(irq_o));
  dasp_line_model u_dasp_line_model_0 (.clk_i(clk_i), .txd_i(txd_o[0]), .rxd_o(mdl_rxd[0]),
    .got_o(got[0]), .frame_o(fr0));
  dasp_line_model u_dasp_line_model_1 (.clk_i(clk_i), .txd_i(txd_o[1]), .rxd_o(mdl_rxd[1]),
    .got_o(got[1]), .frame_o(fr1));
  task automatic print_verdict();
    $display("Counts: checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic cmp(input logic [8:0] g, input logic [8:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  // Timer 1 overflow pulses, cycle ceiling against hangs
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    t1_i <= (t1_per != 0) && (cycles % t1_per == 0);
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // Watcher: takes the oldest note whenever a result shows up
  always @(posedge clk_i) begin
    rd_d <= rd_i;
    sck_d <= sck_o;
    if (sck_o[0] && !sck_d[0]) begin
      sh <= {rxd_line[0], sh[7:1]};
      n_sck++;
    end
    if (rd_d) cmp({1'b0, rdata_o}, {1'b0, exp_q.pop_front()});
    if (got[0] === 1'b1) cmp(fr0, txq0.pop_front());
    if (got[1] === 1'b1) cmp(fr1, txq1.pop_front());
  end
  function automatic logic [7:0] ra(input logic p, input logic [3:0] r);
    return {3'b000, p, r};
  endfunction : ra
  // Strobe tasks leave a quiet cycle so no signal is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask : rd
  task automatic cfg(input logic p, input int b, input int nb);
    if (p) begin
      u_dasp_line_model_1.bit_clks = b;
      u_dasp_line_model_1.n_bits = nb;
    end else begin
      u_dasp_line_model_0.bit_clks = b;
      u_dasp_line_model_0.n_bits = nb;
    end
  endtask : cfg
  task automatic snd(input logic p, input logic [8:0] w);
    if (p) u_dasp_line_model_1.send(w);
    else u_dasp_line_model_0.send(w);
  endtask : snd
  // Send and receive one frame at once on a port, then check flags and data
  task automatic xfer(input logic p, input logic [7:0] c, input logic [7:0] pr,
    input logic [7:0] rl, input int b);
    int nb;
    logic [8:0] tw, rw;
    nb = (c[1:0] == DASP_MODE_8VAR) ? 8 : 9;
    tw = {c[DASP_CTRL_TB8] && nb == 9, 8'($urandom)};
    rw = {nb == 9, 8'($urandom)};
    wr(ra(p, DASP_REG_IRQ_CLR), 8'h07);
    wr(ra(p, DASP_REG_PRESC), pr);
    wr(ra(p, DASP_REG_RELOAD), rl);
    wr(ra(p, DASP_REG_CTRL), c);
    cfg(p, b, nb);
    if (p) txq1.push_back(tw);
    else txq0.push_back(tw);
    fork
      snd(p, rw);
      wr(ra(p, DASP_REG_DATA), tw[7:0]);
    join
    repeat (b) @(posedge clk_i);
    rd(ra(p, DASP_REG_STATUS), 8'h03);
    rd(ra(p, DASP_REG_DATA), rw[7:0]);
    if (nb == 9) rd(ra(p, DASP_REG_NINTH), {7'h00, rw[8]});
    $display("Test done: port %0d ctrl %h", p, c);
  endtask : xfer
  initial begin
    logic [7:0] pr, rl;
    void'($urandom(10));
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(ra(0, DASP_REG_CTRL), DASP_CTRL_RST);
    rd(ra(1, DASP_REG_RELOAD), DASP_RELOAD_RST);
    rd(ra(1, DASP_REG_PRESC), DASP_PRESC_RST);
    rd(8'h24, 8'h00);
    $display("Test done: reset values and unmapped read");
    xfer(1'b0, 8'h05, 8'h00, 8'h00, 16);
    xfer(1'b1, 8'h47, 8'h01, 8'h02, 96);
    xfer(1'b0, 8'h16, 8'h00, 8'h00, 32);
    xfer(1'b0, 8'h06, 8'h00, 8'h00, 64);
    xfer(1'b1, 8'h16, 8'h00, 8'h00, 64);
    t1_per = 3;
    xfer(1'b0, 8'h25, 8'h05, 8'h05, 48);
    t1_per = 0;
    pr = 8'($urandom % 2);
    rl = 8'($urandom % 3);
    xfer(1'b1, 8'h05, pr, rl, 16 * (pr + 1) * (rl + 1));
    // Second byte arrives while the first waits; then one too many
    wr(ra(0, DASP_REG_IRQ_CLR), 8'h07);
    wr(ra(0, DASP_REG_CTRL), 8'h05);
    wr(ra(0, DASP_REG_PRESC), 8'h00);
    wr(ra(0, DASP_REG_RELOAD), 8'h00);
    cfg(1'b0, 16, 8);
    snd(1'b0, 9'h0a5);
    fork
      snd(1'b0, 9'h03c);
      rd(ra(0, DASP_REG_DATA), 8'ha5);
    join
    repeat (16) @(posedge clk_i);
    rd(ra(0, DASP_REG_DATA), 8'h3c);
    snd(1'b0, 9'h011);
    snd(1'b0, 9'h022);
    repeat (16) @(posedge clk_i);
    rd(ra(0, DASP_REG_DATA), 8'h11);
    rd(ra(0, DASP_REG_STATUS), 8'h04);
    $display("Test done: receive buffering and overrun");
    // Address filter: a frame with ninth bit 0 is dropped
    wr(ra(1, DASP_REG_IRQ_CLR), 8'h07);
    wr(ra(1, DASP_REG_PRESC), 8'h00);
    wr(ra(1, DASP_REG_RELOAD), 8'h00);
    wr(ra(1, DASP_REG_CTRL), 8'h0f);
    cfg(1'b1, 16, 9);
    snd(1'b1, 9'h055);
    snd(1'b1, 9'h1aa);
    repeat (16) @(posedge clk_i);
    rd(ra(1, DASP_REG_STATUS), 8'h02);
    rd(ra(1, DASP_REG_DATA), 8'haa);
    rd(ra(1, DASP_REG_NINTH), 8'h01);
    $display("Test done: address filter");
    // Interrupt raised, cleared, masked, unmasked
    wr(ra(1, DASP_REG_CTRL), 8'h05);
    cfg(1'b1, 16, 8);
    wr(ra(1, DASP_REG_IRQ_EN), 8'h01);
    txq1.push_back(9'h0c3);
    wr(ra(1, DASP_REG_DATA), 8'hc3);
    rd(ra(1, DASP_REG_STATUS), 8'h08);
    for (int i = 0; i < 400 && irq_o !== 1'b1; i++) @(posedge clk_i);
    cmp({8'h00, irq_o}, 9'h001);
    wr(ra(1, DASP_REG_IRQ_CLR), 8'h01);
    // The request flop follows the flags one edge later
    @(posedge clk_i);
    cmp({8'h00, irq_o}, 9'h000);
    wr(ra(1, DASP_REG_IRQ_EN), 8'h00);
    snd(1'b1, 9'h05a);
    repeat (16) @(posedge clk_i);
    cmp({8'h00, irq_o}, 9'h000);
    wr(ra(1, DASP_REG_IRQ_EN), 8'h02);
    @(posedge clk_i);
    cmp({8'h00, irq_o}, 9'h001);
    rd(ra(1, DASP_REG_DATA), 8'h5a);
    $display("Test done: interrupt");
    // Shift register mode: eight bits on the rx pin, two clocks each
    pr = 8'($urandom);
    n_sck = 0;
    wr(ra(0, DASP_REG_CTRL), 8'h00);
    wr(ra(0, DASP_REG_DATA), pr);
    repeat (40) @(posedge clk_i);
    cmp({1'b0, sh}, {1'b0, pr});
    cmp(9'(n_sck), 9'd8);
    cmp(9'(exp_q.size() + txq0.size() + txq1.size()), 9'd0);
    $display("Test done: shift register mode");
    print_verdict();
  end
endmodule : dual_async_serial_port_bench
`default_nettype wire
